// ---- pkg/sscs_consts.vh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the design file and the bench of the serial block
`ifndef SSCS_CONSTS_VH
`define SSCS_CONSTS_VH

`define SSCS_OFF_CTRL      8'h00
`define SSCS_OFF_MODE      8'h04
`define SSCS_OFF_RXDATA    8'h08
`define SSCS_OFF_TXDATA    8'h0c
`define SSCS_OFF_STATUS    8'h10
`define SSCS_OFF_IRQ_EN    8'h14
`define SSCS_OFF_IRQ_DIS   8'h18
`define SSCS_OFF_IRQ_MASK  8'h1c
`define SSCS_OFF_CFG0      8'h30
`define SSCS_OFF_CFG3      8'h3c

`define SSCS_CTRL_ENABLE   0
`define SSCS_CTRL_DISABLE  1

`define SSCS_MODE_MASTER   0
`define SSCS_MODE_VARSEL   1
`define SSCS_MODE_DECODER  2
`define SSCS_MODE_PRESCALE 3
`define SSCS_MODE_NOFAULT  4
`define SSCS_MODE_PCS_LSB  16
`define SSCS_MODE_WMASK    32'h000f001f
`define SSCS_MODE_RESET    32'h00000000

`define SSCS_CFG_WMASK     32'hfffffff3
`define SSCS_CFG_RESET     32'h00000000

`define SSCS_TXD_PCS_LSB   16
`define SSCS_STAT_ENABLED  16

`define SSCS_PRESCALE      5'h1f
`define SSCS_GAP_MIN       16'h0004
`define SSCS_GAP_SHIFT     5
`define SSCS_MIN_DIVISOR   8'h02
`define SSCS_PIN_IDLE      4'hf
`define SSCS_RESP_OKAY     2'b00
`define SSCS_RESP_SLVERR   2'b10

`endif

// ---- logic/sscs_core.v ----
// Serial master core: flags, irq mask, select config and serializer on AXI4-Lite
// Assumes synchronous inputs on mclk; DMA counters report by strobes and levels
//
// Contract
// - Received chip-select field shows pin levels in master mode, else zero.
// - Transmit word chip-select used only when variable select active.
// - Without decoder, pins priority decode; code 1111 never used.
// - With decoder on, pins carry the chip-select code directly.
// - Receive-full sets on load from serializer, clears on data read.
// - Transmit-empty low at reset, disabled, after write; set by enable, handoff.
// - Mode fault sets flag; status read clears it.
// - Overrun sets on second load without data read; status read clears.
// - Count-done flags set at counter zero, clear on counter writes.
// - All-counts-zero flags high exactly when both counters are zero.
// - Status bit 16 shows whether the interface is enabled.
// - Enable writes set mask bits, disable writes clear, zeros ignored.
// - Mask view reads one where interrupt is enabled.
// - Configuration bit 0 sets serial clock idle level.
// - Phase bit selects change and capture edges.
// - Word-length field 0 to 8 gives 8 to 16 bits.
// - Serial clock is clock over twice divisor, or 64 times with prescale.
// - Divisor zero or one stops clock at idle, no transfers.
// - Lead delay zero gives half period, else field cycles, times 32 prescaled.
// - Inter-word delay 4 or 32 times field cycles, scaled by 32 prescaled.
// - Inter-word delay after every word, chip select held during it.
// - Prescale bit runs interface from clock divided by 32.
// - Mode bit chooses fixed or per-word chip-select.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`include "sscs_consts.vh"
`timescale 1ns/10ps

module sscs_core (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        mode_fault_detect,
    input  wire        rx_count_hit_zero,
    input  wire        rx_count_write,
    input  wire        rx_count_zero,
    input  wire        rx_next_count_zero,
    input  wire        tx_count_hit_zero,
    input  wire        tx_count_write,
    input  wire        tx_count_zero,
    input  wire        tx_next_count_zero,
    input  wire        serial_data_in,
    output reg         serial_data_out,
    output reg         serial_clock_pin,
    output reg  [3:0]  chip_select_pins,
    output reg         irq
);

    localparam [3:0] S_IDLE  = 4'b0001;
    localparam [3:0] S_LEAD  = 4'b0010;
    localparam [3:0] S_SHIFT = 4'b0100;
    localparam [3:0] S_GAP   = 4'b1000;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire        rd_fire = s_axi_arvalid & ~s_axi_rvalid;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wd = w_data & wmask;
    wire [7:0]  ra = s_axi_araddr[7:0];

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_ctrl  = wr_fire & (aw_addr == `SSCS_OFF_CTRL);
    wire wr_mode  = wr_fire & (aw_addr == `SSCS_OFF_MODE);
    wire wr_txd   = wr_fire & (aw_addr == `SSCS_OFF_TXDATA);
    wire wr_ien   = wr_fire & (aw_addr == `SSCS_OFF_IRQ_EN);
    wire wr_idis  = wr_fire & (aw_addr == `SSCS_OFF_IRQ_DIS);
    wire wr_cfg   = wr_fire & (aw_addr >= `SSCS_OFF_CFG0) & (aw_addr <= `SSCS_OFF_CFG3) & (aw_addr[1:0] == 2'b00);
    wire wr_ok    = wr_ctrl | wr_mode | wr_txd | wr_ien | wr_idis | wr_cfg;
    wire rd_rxd   = rd_fire & (ra == `SSCS_OFF_RXDATA);
    wire rd_stat  = rd_fire & (ra == `SSCS_OFF_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Registers and flags
    reg         enabled;
    reg  [31:0] mode_reg;
    reg  [31:0] cfg [0:3];
    reg  [15:0] tx_word;
    reg  [3:0]  tx_pcs;
    reg  [15:0] rx_word;
    reg  [3:0]  rx_pcs;
    reg  [7:0]  irq_mask;
    reg         rx_full_flag;
    reg         tx_empty_flag;
    reg         mode_fault_flag;
    reg         overrun_flag;
    reg         rx_count_done;
    reg         tx_count_done;

    wire master_mode           = mode_reg[`SSCS_MODE_MASTER];
    wire variable_select_enable = mode_reg[`SSCS_MODE_VARSEL];
    wire select_decoder_mode   = mode_reg[`SSCS_MODE_DECODER];
    wire prescale_by_thirtytwo = mode_reg[`SSCS_MODE_PRESCALE];
    wire fault_check_off       = mode_reg[`SSCS_MODE_NOFAULT];
    wire [3:0] fixed_select    = mode_reg[`SSCS_MODE_PCS_LSB+3:`SSCS_MODE_PCS_LSB];

    wire rx_all_counts_zero = rx_count_zero & rx_next_count_zero;
    wire tx_all_counts_zero = tx_count_zero & tx_next_count_zero;
    wire [7:0] status_bits = {tx_all_counts_zero, rx_all_counts_zero, tx_count_done, rx_count_done,
                              overrun_flag, mode_fault_flag, tx_empty_flag, rx_full_flag};

    ////////////////////////////////////////////////////////////////////////
    // Chip-select choice
    wire [3:0] chip_select_value = variable_select_enable ? tx_pcs : fixed_select;
    reg  [1:0] sel_idx;
    reg  [3:0] sel_pins;
    always @* begin
        if (select_decoder_mode) begin
            sel_idx  = chip_select_value[3:2];
            sel_pins = chip_select_value;
        end else if (!chip_select_value[0]) begin
            sel_idx  = 2'd0;
            sel_pins = 4'b1110;
        end else if (!chip_select_value[1]) begin
            sel_idx  = 2'd1;
            sel_pins = 4'b1101;
        end else if (!chip_select_value[2]) begin
            sel_idx  = 2'd2;
            sel_pins = 4'b1011;
        end else begin
            sel_idx  = 2'd3;
            sel_pins = 4'b0111;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serializer timing
    reg  [3:0]  state;
    reg  [1:0]  act_idx;
    reg  [3:0]  act_code;
    reg  [4:0]  pre_cnt;
    reg  [15:0] cnt;
    reg  [4:0]  edge_cnt;
    reg  [15:0] sreg;
    reg  [15:0] rx_shift;

    wire [31:0] sel_cfg = cfg[sel_idx];
    wire [31:0] act_cfg = cfg[act_idx];
    wire [7:0]  act_div = act_cfg[15:8];
    wire [3:0]  act_bits = act_cfg[7:4];
    wire [7:0]  act_lead = act_cfg[23:16];
    wire [7:0]  act_gap = act_cfg[31:24];
    wire [3:0]  sel_bits = sel_cfg[7:4];
    wire        tick = ~prescale_by_thirtytwo | (pre_cnt == `SSCS_PRESCALE);
    wire        expire = tick & (cnt == 16'h0001);
    wire        can_run = enabled & master_mode & (sel_cfg[15:8] >= `SSCS_MIN_DIVISOR);
    wire        word_ready = can_run & ~tx_empty_flag & ~wr_txd;
    wire        start_new = (state == S_IDLE) & word_ready;
    wire        continue_word = (state == S_GAP) & expire & word_ready & (chip_select_value == act_code);
    wire        do_load = start_new | continue_word;
    wire        leading = ~edge_cnt[0];
    wire        capture = ~(leading ^ act_cfg[1]);
    wire        do_edge = expire & ((state == S_LEAD) | (state == S_SHIFT));
    wire [4:0]  edge_last = {1'b0, act_bits} + 5'd7;
    wire        final_edge = do_edge & (edge_cnt == {edge_last[3:0], 1'b1});
    wire [15:0] rx_next = capture ? {rx_shift[14:0], serial_data_in} : rx_shift;
    wire [15:0] rx_width_mask = 16'hffff >> (4'd8 - act_bits);
    wire [15:0] tx_aligned = tx_word << (4'd8 - sel_bits);
    wire        rx_load = final_edge;

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt <= 5'h00;
        end else begin
            pre_cnt <= pre_cnt + 5'h01;
        end
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state            <= S_IDLE;
            act_idx          <= 2'd0;
            act_code         <= 4'h0;
            cnt              <= 16'h0000;
            edge_cnt         <= 5'h00;
            sreg             <= 16'h0000;
            rx_shift         <= 16'h0000;
            serial_data_out  <= 1'b0;
            serial_clock_pin <= 1'b0;
            chip_select_pins <= `SSCS_PIN_IDLE;
        end else begin
            if (tick && cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end
            case (state)
                S_IDLE: begin
                    serial_clock_pin <= sel_cfg[0];
                    chip_select_pins <= `SSCS_PIN_IDLE;
                end
                S_LEAD, S_SHIFT: begin
                    if (do_edge) begin
                        serial_clock_pin <= ~serial_clock_pin;
                        edge_cnt         <= edge_cnt + 5'h01;
                        cnt              <= {8'h00, act_div};
                        state            <= S_SHIFT;
                        rx_shift         <= rx_next;
                        if (!capture) begin
                            serial_data_out <= sreg[15];
                            sreg            <= {sreg[14:0], 1'b0};
                        end
                        if (final_edge) begin
                            state <= S_GAP;
                            if (act_gap == 8'h00) begin
                                cnt <= `SSCS_GAP_MIN;
                            end else begin
                                cnt <= {3'b000, act_gap, 5'b00000};
                            end
                        end
                    end
                end
                S_GAP: begin
                    if (expire && !continue_word) begin
                        state            <= S_IDLE;
                        chip_select_pins <= `SSCS_PIN_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
            if (do_load) begin
                act_idx          <= sel_idx;
                act_code         <= chip_select_value;
                chip_select_pins <= sel_pins;
                edge_cnt         <= 5'h00;
                rx_shift         <= 16'h0000;
                serial_clock_pin <= sel_cfg[0];
                if (sel_cfg[1]) begin
                    serial_data_out <= tx_aligned[15];
                    sreg            <= {tx_aligned[14:0], 1'b0};
                end else begin
                    sreg <= tx_aligned;
                end
                if (start_new) begin
                    state <= S_LEAD;
                    if (sel_cfg[23:16] == 8'h00) begin
                        cnt <= {8'h00, sel_cfg[15:8]};
                    end else begin
                        cnt <= {8'h00, sel_cfg[23:16]};
                    end
                end else begin
                    state <= S_SHIFT;
                    cnt   <= {8'h00, sel_cfg[15:8]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and flag updates
    integer i;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enabled         <= 1'b0;
            mode_reg        <= `SSCS_MODE_RESET;
            for (i = 0; i < 4; i = i + 1) begin
                cfg[i] <= `SSCS_CFG_RESET;
            end
            tx_word         <= 16'h0000;
            tx_pcs          <= 4'h0;
            rx_word         <= 16'h0000;
            rx_pcs          <= 4'h0;
            irq_mask        <= 8'h00;
            rx_full_flag    <= 1'b0;
            tx_empty_flag   <= 1'b0;
            mode_fault_flag <= 1'b0;
            overrun_flag    <= 1'b0;
            rx_count_done   <= 1'b0;
            tx_count_done   <= 1'b0;
            irq             <= 1'b0;
        end else begin
            if (wr_ctrl && wd[`SSCS_CTRL_DISABLE]) begin
                enabled       <= 1'b0;
                tx_empty_flag <= 1'b0;
            end else if (wr_ctrl && wd[`SSCS_CTRL_ENABLE]) begin
                enabled       <= 1'b1;
                tx_empty_flag <= 1'b1;
            end else if (wr_txd) begin
                tx_empty_flag <= 1'b0;
            end else if (do_load) begin
                tx_empty_flag <= 1'b1;
            end
            if (wr_mode) begin
                mode_reg <= (mode_reg & ~(wmask & `SSCS_MODE_WMASK)) | (wd & `SSCS_MODE_WMASK);
            end
            if (wr_cfg) begin
                cfg[aw_addr[3:2]] <= (cfg[aw_addr[3:2]] & ~(wmask & `SSCS_CFG_WMASK)) | (wd & `SSCS_CFG_WMASK);
            end
            if (wr_txd) begin
                tx_word <= (tx_word & ~wmask[15:0]) | wd[15:0];
                tx_pcs  <= (tx_pcs & ~wmask[`SSCS_TXD_PCS_LSB+3:`SSCS_TXD_PCS_LSB])
                           | wd[`SSCS_TXD_PCS_LSB+3:`SSCS_TXD_PCS_LSB];
            end
            irq_mask <= (irq_mask | (wr_ien ? wd[7:0] : 8'h00)) & ~(wr_idis ? wd[7:0] : 8'h00);
            if (rx_load) begin
                rx_word <= rx_next & rx_width_mask;
                rx_pcs  <= chip_select_pins;
            end
            if (rx_load) begin
                rx_full_flag <= 1'b1;
            end else if (rd_rxd) begin
                rx_full_flag <= 1'b0;
            end
            if (rx_load && rx_full_flag && !rd_rxd) begin
                overrun_flag <= 1'b1;
            end else if (rd_stat) begin
                overrun_flag <= 1'b0;
            end
            if (mode_fault_detect && !fault_check_off) begin
                mode_fault_flag <= 1'b1;
            end else if (rd_stat) begin
                mode_fault_flag <= 1'b0;
            end
            if (rx_count_hit_zero) begin
                rx_count_done <= 1'b1;
            end else if (rx_count_write) begin
                rx_count_done <= 1'b0;
            end
            if (tx_count_hit_zero) begin
                tx_count_done <= 1'b1;
            end else if (tx_count_write) begin
                tx_count_done <= 1'b0;
            end
            irq <= |(status_bits & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes and read data
    reg [31:0] rd_mux;
    reg        rd_hit;
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (ra)
            `SSCS_OFF_MODE:     rd_mux = mode_reg;
            `SSCS_OFF_RXDATA:   rd_mux = {12'h000, master_mode ? rx_pcs : 4'h0, rx_word};
            `SSCS_OFF_STATUS:   rd_mux = {15'h0000, enabled, 8'h00, status_bits};
            `SSCS_OFF_IRQ_MASK: rd_mux = {24'h000000, irq_mask};
            8'h30:              rd_mux = cfg[0];
            8'h34:              rd_mux = cfg[1];
            8'h38:              rd_mux = cfg[2];
            8'h3c:              rd_mux = cfg[3];
            `SSCS_OFF_CTRL, `SSCS_OFF_TXDATA, `SSCS_OFF_IRQ_EN, `SSCS_OFF_IRQ_DIS: rd_hit = 1'b1;
            default:            rd_hit = 1'b0;
        endcase
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SSCS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `SSCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `SSCS_RESP_OKAY : `SSCS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `SSCS_RESP_OKAY : `SSCS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- test/sscs_asserts.sv ----
// Checker on core ports: bus answers and select timing
// Assumes one clock domain and a bind onto sscs_core
`timescale 1ns/10ps
module sscs_asserts (
    input wire        mclk,
    input wire        sys_rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        serial_clock_pin,
    input wire [3:0]  chip_select_pins
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    reg       last_sck;
    reg [3:0] quiet;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            last_sck <= 1'b0;
            quiet <= 4'h0;
        end else begin
            last_sck <= serial_clock_pin;
            quiet <= (serial_clock_pin != last_sck) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
        end
    end
    a_gap_held: assert property ($rose(&chip_select_pins) |-> quiet >= 4'h2)
        else $error("select released early");
    a_lead_quiet: assert property ($fell(&chip_select_pins) |-> $stable(serial_clock_pin))
        else $error("clock moved in lead");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while busy");
    a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h20
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read ok");
endmodule
bind sscs_core sscs_asserts chk_i (.*);

// ---- test/sscs_peer.sv ----
// Peripheral model on the serial link: shifts a word out and in
// Assumes settings stable per frame
`timescale 1ns/10ps
module sscs_peer (
    input  wire [3:0]  chip_select_pins,
    input  wire        serial_clock_pin,
    input  wire        serial_data_out,
    input  wire        p_clock_idle_level,
    input  wire        p_cpha,
    input  wire [4:0]  p_bits,
    input  wire [15:0] p_word,
    output reg         serial_data_in,
    output reg  [15:0] p_got
);
    wire    sel_n = &chip_select_pins;
    integer idx;
    initial serial_data_in = 1'b0;
    // Released line flips
    always @(posedge sel_n) serial_data_in = ~serial_data_in;
    always @(negedge sel_n) begin
        idx = p_bits - 1;
        p_got = 16'h0;
        if (p_cpha) serial_data_in = p_word[idx];
    end
    always @(serial_clock_pin) begin
        if (!sel_n && ((serial_clock_pin != p_clock_idle_level) == p_cpha)) p_got = {p_got[14:0], serial_data_out};
        else if (!sel_n) begin
            if (p_cpha) idx = idx - 1;
            if (idx >= 0) serial_data_in = p_word[idx];
            if (!p_cpha) idx = idx - 1;
        end
    end
endmodule

// ---- test/test_sscs_core.sv ----
// Bench: registers, flags, mask, irq and frames of the serial core
// Assumes core, peer and checker compiled first
`include "sscs_consts.vh"
`timescale 1ns/10ps
module test_sscs_core;
    reg        mclk = 1'b0, sys_rst = 1'b1;
    reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d, v, cfg;
    reg [3:0]  s_axi_wstrb = 4'hf, code, pins;
    reg        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
    reg        s_axi_rready = 1'b1, mode_fault_detect = 1'b0, rx_count_hit_zero = 1'b0, tx_count_hit_zero = 1'b0;
    reg        rx_count_write = 1'b0, tx_count_write = 1'b0, rx_count_zero = 1'b0, rx_next_count_zero = 1'b0;
    reg        tx_count_zero = 1'b0, tx_next_count_zero = 1'b0, p_clock_idle_level = 1'b0, p_cpha = 1'b0;
    reg [4:0]  p_bits = 5'h8;
    reg [15:0] p_word = 16'h0, msk, tx;
    reg [7:0]  m_mask = 8'h0;
    reg        m_rxf = 1'b0, m_txe = 1'b0, m_mf = 1'b0, m_ov = 1'b0, m_rd = 1'b0, m_td = 1'b0, m_en = 1'b0;
    wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire       serial_data_in, serial_data_out, serial_clock_pin, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] chip_select_pins;
    wire [15:0] p_got;
    integer    bad_count = 0, num_checks = 0, cyc = 0, i, j, k;
    sscs_core dut (.*);
    sscs_peer peer (.*);
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    function [31:0] m_stat();
        m_stat = {15'h0, m_en, 8'h0, tx_count_zero & tx_next_count_zero, rx_count_zero & rx_next_count_zero,
            m_td, m_rd, m_ov, m_mf, m_txe, m_rxf};
    endfunction
    task chk(input [31:0] e, input [31:0] g, input [63:0] what);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("BAD %0s expected %h seen %h", what, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] dv);
        reg ad, dd;
        begin
            ad = 1'b0;
            dd = 1'b0;
            s_axi_awaddr <= {24'h0, a};
            s_axi_wdata <= dv;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            while (!(ad && dd)) begin
                @(posedge mclk);
                ad = ad | s_axi_awready;
                dd = dd | s_axi_wready;
                s_axi_awvalid <= !ad;
                s_axi_wvalid <= !dd;
            end
            do @(posedge mclk); while (!s_axi_bvalid);
        end
    endtask
    task rd(input [7:0] a, output [31:0] dv);
        begin
            s_axi_araddr <= {24'h0, a};
            s_axi_arvalid <= 1'b1;
            do @(posedge mclk); while (!s_axi_arready);
            s_axi_arvalid <= 1'b0;
            do @(posedge mclk); while (!s_axi_rvalid);
            dv = s_axi_rdata;
        end
    endtask
    task rs;
        begin
            rd(`SSCS_OFF_STATUS, d);
            chk(m_stat(), d, "status");
            {m_mf, m_ov} = 2'h0;
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i = $urandom(94807);
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rs;
        for (i = 0; i < 6; i = i + 1) begin
            v = $urandom;
            wr(`SSCS_OFF_IRQ_EN, v);
            m_mask = m_mask | v[7:0];
            v = $urandom;
            wr(`SSCS_OFF_IRQ_DIS, v);
            m_mask = m_mask & ~v[7:0];
            {rx_count_zero, rx_next_count_zero, tx_count_zero, tx_next_count_zero} <= v[11:8];
            rd(`SSCS_OFF_IRQ_MASK, d);
            chk({24'h0, m_mask}, d, "mask");
            rs;
            chk(|(m_stat() & m_mask), irq, "irq");
        end
        $display("mask test done");
        {mode_fault_detect, rx_count_hit_zero, tx_count_hit_zero} <= 3'h7;
        @(posedge mclk);
        {mode_fault_detect, rx_count_hit_zero, tx_count_hit_zero} <= 3'h0;
        {m_mf, m_rd, m_td} = 3'h7;
        rs;
        rx_count_write <= 1'b1;
        @(posedge mclk);
        {rx_count_write, tx_count_write} <= 2'h1;
        m_rd = 1'b0;
        rs;
        tx_count_write <= 1'b0;
        m_td = 1'b0;
        wr(`SSCS_OFF_CTRL, 32'h1);
        {m_en, m_txe} = 2'h3;
        rs;
        $display("flag test done");
        for (i = 0; i < 8; i = i + 1) begin
            v = $urandom;
            k = v[1:0];
            code = v[7:4];
            if (i[1]) code = (code == 4'hf) ? 4'he : code;
            else code = k == 3 ? 4'h7 : k == 2 ? {code[3], 3'h3} : k == 1 ? {code[3:2], 2'h1} : {code[3:1], 1'b0};
            pins = i[1] ? code : ~(4'h1 << k);
            j = v[13:10] % 9;
            msk = 16'hffff >> (8 - j);
            cfg = {7'h0, v[31], 6'h0, v[29:28], 8'h2 + v[9:8], j[3:0], 2'h0, v[14], v[15]};
            for (k = 0; k < 4; k = k + 1) wr(`SSCS_OFF_CFG0 + {k[5:0], 2'h0}, cfg);
            wr(`SSCS_OFF_MODE, {12'h0, i[0] ? v[23:20] : code, 13'h0, i[1], i[0], 1'b1});
            d = $urandom;
            {p_clock_idle_level, p_cpha} <= {v[15], v[14]};
            p_bits <= {1'b0, j[3:0]} + 5'h8;
            p_word <= d[15:0] & msk;
            tx = d[31:16] & msk;
            wr(`SSCS_OFF_TXDATA, {12'h0, i[0] ? code : v[23:20], tx});
            while (&chip_select_pins) @(posedge mclk);
            chk(pins, chip_select_pins, "pins");
            while (!(&chip_select_pins)) @(posedge mclk);
            chk(v[15], serial_clock_pin, "sclk");
            chk(tx, p_got, "peer");
            rd(`SSCS_OFF_RXDATA, d);
            chk({12'h0, pins, p_word}, d, "rxdata");
            rs;
        end
        wr(`SSCS_OFF_TXDATA, {12'h0, code, tx});
        while (&chip_select_pins) @(posedge mclk);
        wr(`SSCS_OFF_TXDATA, {12'h0, code, tx});
        while (!(&chip_select_pins)) @(posedge mclk);
        {m_rxf, m_ov} = 2'h3;
        rs;
        for (k = 0; k < 4; k = k + 1) wr(`SSCS_OFF_CFG0 + {k[5:0], 2'h0}, cfg & 32'hffff00ff);
        wr(`SSCS_OFF_TXDATA, {12'h0, code, tx});
        m_txe = 1'b0;
        repeat (300) @(posedge mclk);
        chk(4'hf, chip_select_pins, "pins");
        rs;
        wr(`SSCS_OFF_MODE, 32'h0);
        rd(`SSCS_OFF_RXDATA, d);
        chk(4'h0, d[19:16], "rxsel");
        m_rxf = 1'b0;
        rd(8'h20, d);
        wr(`SSCS_OFF_CTRL, 32'h2);
        m_en = 1'b0;
        rs;
        $display("frame test done");
        end_of_test;
    end
endmodule
